// >>> rtl/sar_readout_pkg.sv
// Constants, encodings and timing figures for the serial readout of the
// successive-approximation converter family (12-, 10- and 8-bit variants).
// Assumes a single core clock of 250 MHz; serial pins are sampled on it.
package sar_readout_pkg;

    // Result and frame geometry.
    localparam int RESULT_W = 12;
    localparam int FRAME_W = 16;
    localparam int FIFO_DEPTH = 8;

    // Serial clock falling-edge counts within one frame.
    localparam logic [4:0] FRAME_CLKS = 5'h10;
    localparam logic [4:0] LOAD_EDGE = 5'h04;
    localparam logic [4:0] PD_FIRST_EDGE = 5'h02;
    localparam logic [4:0] PD_LAST_EDGE = 5'h0a;
    localparam logic [4:0] CONV_LEN_12 = 5'h10;
    localparam logic [4:0] CONV_LEN_10 = 5'h0e;
    localparam logic [4:0] CONV_LEN_8 = 5'h0c;
    localparam logic [4:0] TRACK_AFTER_12 = 5'h0d;
    localparam logic [4:0] TRACK_AFTER_10 = 5'h0d;
    localparam logic [4:0] TRACK_AFTER_8 = 5'h0b;

    // Variant strap encodings on the select pins.
    localparam logic [1:0] SEL_12 = 2'h0;
    localparam logic [1:0] SEL_10 = 2'h1;
    localparam logic [1:0] SEL_8 = 2'h2;

    // Host-side timing, kept here so the bench host model can pace its frames.
    localparam int CLK_MHZ = 250;
    localparam int ACQ_NS = 225;
    localparam int QUIET_NS = 50;
    localparam int ACQ_CYCLES = (ACQ_NS * CLK_MHZ + 999) / 1000;
    localparam int QUIET_CYCLES = (QUIET_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {VAR_12, VAR_10, VAR_8} variant_type;
    typedef enum logic {ST_IDLE, ST_FRAME} frame_state_type;

endpackage : sar_readout_pkg

// >>> rtl/result_stream_if.sv
// Valid/ready word stream between the readout top and its result FIFO.
// Assumes both ends sit on the same core clock.
`timescale 1ns/10ps
`default_nettype none

interface result_stream_if #(parameter int WIDTH = 12);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport producer (output valid, output data, input ready);
    modport consumer (input valid, input data, output ready);
endinterface : result_stream_if

`default_nettype wire

// >>> rtl/result_fifo.sv
// Flip-flop FIFO holding conversion results until the serial frame needs them.
// Assumes a power-of-two depth and one clock for both sides.
`timescale 1ns/10ps
`default_nettype none

module result_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // Fill and drain streams.
    result_stream_if.consumer fill,
    result_stream_if.producer drain
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire push = fill.valid & fill.ready;
    wire pop = drain.valid & drain.ready;

    assign fill.ready = (count != (AW+1)'(DEPTH));
    assign drain.valid = (count != '0);
    assign drain.data = mem[rd_ptr];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_entry
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    mem[i] <= '0;
                end else if (push && wr_ptr == AW'(i)) begin
                    mem[i] <= fill.data;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + AW'(1);
            if (pop) rd_ptr <= rd_ptr + AW'(1);
            if (push && !pop) count <= count + (AW+1)'(1);
            else if (pop && !push) count <= count - (AW+1)'(1);
        end
    end

endmodule : result_fifo

`default_nettype wire

// >>> rtl/sar_adc_serial_readout.sv
// Serial readout and conversion sequencing of a SAR converter family.
// Assumes the host drives chip select and serial clock asynchronously to
// core_clk, slow enough that every serial edge spans several core clocks.
// Results arrive from the converter core over a valid/ready stream.
// Limitation: a strap change in mid-frame takes effect at once, so the
// straps are meant to stay put while a frame is open.
// Function
// RULE_01: Chip-select fall holds, samples, starts, drives output.
// RULE_02: Serial clock edges pace conversion and shifting.
// RULE_03: Twelve-bit frame takes sixteen serial clocks.
// RULE_04: Twelve-bit tracks at rise after thirteenth fall.
// RULE_05: Twelve-bit output released on sixteenth fall.
// RULE_06: Twelve-bit early chip-select rise aborts, releases.
// RULE_07: Ten-bit conversion takes fourteen serial clocks.
// RULE_08: Ten-bit tracks at rise after thirteenth fall.
// RULE_09: Ten-bit early chip-select rise aborts, releases.
// RULE_10: Ten/eight-bit output released on sixteenth fall.
// RULE_11: Pad sixteen-clock frames with trailing zeros.
// RULE_12: Eight-bit conversion takes twelve serial clocks.
// RULE_13: Eight-bit tracks at rise after eleventh fall.
// RULE_14: Eight-bit early chip-select rise aborts, releases.
// RULE_15: Chip-select fall drives first zero, falls shift.
// RULE_16: Last twelve-bit bit shifted on fifteenth fall.
// RULE_17: Slow host may capture on rising edges.
// RULE_18: Late chip-select fall still shows first zero.
// RULE_19: Host may end eight-bit frame at twelfth rise; the code counts a rise before the twelfth fall as an abort.
// RULE_20: Host keeps acquisition and quiet times.
// RULE_21: Host requests power-down with short frame.
// RULE_22: Host spaces frames by whole serial periods.
// RULE_23: Rise between second and tenth fall powers down.
// RULE_24: Wake by holding select past tenth fall.
// RULE_25: Result shifted most significant bit first.
`timescale 1ns/10ps
`default_nettype none

module sar_adc_serial_readout (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // Serial pins from and to the host.
    input wire logic cs_n,
    input wire logic sclk,
    output logic serial_result_out,
    output logic serial_result_oe,
    // Variant strap pins.
    input wire logic [1:0] variant_sel,
    // Converter core control.
    output logic track_hold_hold,
    output logic conv_start,
    output logic conv_step,
    output logic conv_abort,
    // Results from the converter core.
    input wire logic [sar_readout_pkg::RESULT_W-1:0] result_data,
    input wire logic result_valid,
    output logic result_ready,
    // Status.
    output logic power_down,
    output logic fully_powered,
    output logic frame_active
);
    import sar_readout_pkg::*;

    // The stream carriers come first, as the shifter and the ready output
    // below both read them.
    result_stream_if #(.WIDTH(RESULT_W)) fill_if ();
    result_stream_if #(.WIDTH(RESULT_W)) drain_if ();

    // Pin synchronisers: stage 0 is read only by stage 1; stage 2 is the
    // previous settled value used for edge detection.
    // Reset values equal the idle pin levels, so no false edge follows reset.
    logic [2:0] cs_pipe;
    logic [2:0] sclk_pipe;
    logic [1:0] sel_meta;
    logic [1:0] sel_sync;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cs_pipe <= 3'h7;
            sclk_pipe <= 3'h0;
            sel_meta <= SEL_12;
            sel_sync <= SEL_12;
        end else begin
            cs_pipe <= {cs_pipe[1:0], cs_n};
            sclk_pipe <= {sclk_pipe[1:0], sclk};
            sel_meta <= variant_sel;
            sel_sync <= sel_meta;
        end
    end

    // A serial edge is seen three core clocks after the pin moves; the host
    // must hold each serial phase longer than that.
    wire cs_fall = cs_pipe[2] & ~cs_pipe[1];
    wire cs_rise = ~cs_pipe[2] & cs_pipe[1];
    wire sclk_fall = sclk_pipe[2] & ~sclk_pipe[1];
    wire sclk_rise = ~sclk_pipe[2] & sclk_pipe[1];

    // Variant decode; unused encodings fall back to the 12-bit behaviour.
    variant_type variant;
    assign variant = (sel_sync == SEL_10) ? VAR_10 :
                     (sel_sync == SEL_8) ? VAR_8 : VAR_12;

    // RULE_03 conversion length select.
    // RULE_07 conversion length select.
    // RULE_12 conversion length select.
    wire [4:0] conv_len = (variant == VAR_10) ? CONV_LEN_10 :
                          (variant == VAR_8) ? CONV_LEN_8 : CONV_LEN_12;
    // Track resumes at the first serial rise after this many falls.
    wire [4:0] track_edge = (variant == VAR_10) ? TRACK_AFTER_10 :
                            (variant == VAR_8) ? TRACK_AFTER_8 : TRACK_AFTER_12;

    // Frame state and counters.
    // The frame word holds the whole loaded result word; the count holds the falls seen.
    frame_state_type state;
    logic [4:0] fall_cnt;
    logic [FRAME_W-1:0] frame_word;
    logic warming;

    wire in_frame = (state == ST_FRAME);
    wire start = cs_fall & ~in_frame;
    wire frame_end = in_frame & cs_rise;
    // RULE_02 steps only on serial falls.
    wire step = in_frame & sclk_fall & ~cs_rise;
    // The count saturates at the frame length so that a host sending extra
    // clocks cannot wrap it back into the result bits.
    wire cnt_sat = (fall_cnt == FRAME_CLKS);
    wire [4:0] next_cnt = cnt_sat ? fall_cnt : fall_cnt + 5'h01;
    // The result is fetched on the fourth fall, just as its first bit is due,
    // which leaves the core the whole leading-zero time to deliver it.
    wire load_now = step & (next_cnt == LOAD_EDGE);

    // RULE_11 trailing zero padding.
    // RULE_25 most significant first.
    // Shorter results sit just below the four leading zeros and are padded
    // with trailing zeros up to sixteen bits.
    logic [FRAME_W-1:0] formatted;
    always_comb begin
        formatted = '0;
        // An empty FIFO yields an all-zero result rather than stale data.
        if (drain_if.valid) begin
            case (variant)
                VAR_12: formatted = {4'h0, drain_if.data};
                VAR_10: formatted = {4'h0, drain_if.data[9:0], 2'h0};
                VAR_8: formatted = {4'h0, drain_if.data[7:0], 4'h0};
                default: formatted = '0;
            endcase
        end
    end

    wire [FRAME_W-1:0] word_sel = load_now ? formatted : frame_word;
    // Bit 15-n of the frame word goes out on fall n, most significant first.
    wire [3:0] bit_idx = 4'(FRAME_W - 1) - next_cnt[3:0];
    wire next_bit = word_sel[bit_idx];

    // RULE_05 release on sixteenth fall.
    // RULE_10 release on sixteenth fall.
    wire end_drive = step & (next_cnt == FRAME_CLKS);
    // A chip-select rise counts as a normal end once the variant's
    // conversion length has been clocked; earlier it cuts the conversion.
    wire complete = (fall_cnt >= conv_len);
    wire abort = frame_end & ~complete;
    // The window is judged on falls already counted, so a rise before the
    // second fall is taken as a glitch and leaves the power state alone.
    // RULE_23 power-down window.
    wire pd_window = (fall_cnt >= PD_FIRST_EDGE) && (fall_cnt < PD_LAST_EDGE);
    wire enter_pd = frame_end & pd_window;
    // RULE_24 wake past tenth fall.
    wire wake_clear = power_down & step & (next_cnt == PD_LAST_EDGE);
    // Warming marks the dummy frame that follows power-down.
    wire wake_done = warming & step & (next_cnt == FRAME_CLKS);
    // After power-down the sample stage returns to track at the first serial
    // edge of the dummy frame, whichever direction it is.
    // RULE_04 track after count.
    // RULE_08 track after count.
    // RULE_13 track after count.
    wire track_now = in_frame & ~cs_rise &
                     ((sclk_rise & (fall_cnt >= track_edge)) |
                      (warming & (sclk_rise | sclk_fall)));

    // The core sees ready for as long as the FIFO has room.
    assign result_ready = fill_if.ready;

    // The frame state follows the synchronised chip select only; serial
    // clocks seen while idle are ignored, which keeps a free-running host
    // clock harmless.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            fall_cnt <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_FRAME;
                        fall_cnt <= '0;
                    end
                end
                ST_FRAME: begin
                    if (cs_rise) state <= ST_IDLE;
                    else if (step) fall_cnt <= next_cnt;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Output shifter and driver enable.
    // A cut frame takes priority over a shift, so a serial fall that meets
    // the chip-select rise never drives a stale bit.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            frame_word <= '0;
            serial_result_out <= 1'b0;
            serial_result_oe <= 1'b0;
        end else if (start) begin
            // RULE_01 drive on chip-select fall.
            // RULE_15 first leading zero.
            // RULE_18 zero valid immediately.
            frame_word <= '0;
            serial_result_out <= 1'b0;
            serial_result_oe <= 1'b1;
        end else if (frame_end) begin
            // RULE_06 abort releases output.
            // RULE_09 abort releases output.
            // RULE_14 abort releases output.
            serial_result_oe <= 1'b0;
        end else if (end_drive) begin
            serial_result_oe <= 1'b0;
        end else if (step) begin
            // RULE_16 shift on each fall.
            frame_word <= word_sel;
            serial_result_out <= next_bit;
        end
    end

    // Track/hold, power state and core strobes.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            track_hold_hold <= 1'b0;
        end else if (start) begin
            // RULE_01 hold and sample.
            track_hold_hold <= 1'b1;
        end else if (frame_end) begin
            // A sleeping converter keeps its sample stage in hold.
            // A normal end leaves it tracking for the next acquisition.
            track_hold_hold <= enter_pd | (power_down & ~wake_clear);
        end else if (track_now) begin
            track_hold_hold <= 1'b0;
        end
    end

    // Power-down is entered only at a frame end and left only on a counted
    // fall, never on a bare chip-select edge, to ride out select glitches.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            power_down <= 1'b0;
            warming <= 1'b0;
        end else begin
            // RULE_23 enter power-down.
            if (enter_pd) power_down <= 1'b1;
            else if (wake_clear) power_down <= 1'b0;
            if (start && power_down) warming <= 1'b1;
            else if (wake_done || frame_end) warming <= 1'b0;
        end
    end

    // Core strobes are registered copies of the internal events and lag
    // them by one core clock; fully_powered lags power_down and warming the same way.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            conv_start <= 1'b0;
            conv_step <= 1'b0;
            conv_abort <= 1'b0;
            fully_powered <= 1'b1;
            frame_active <= 1'b0;
        end else begin
            conv_start <= start;
            conv_step <= step;
            conv_abort <= abort;
            fully_powered <= ~power_down & ~warming;
            frame_active <= in_frame;
        end
    end

    // Result buffering between the converter core and the shifter.
    // The core may run ahead of the host by up to the FIFO depth; beyond
    // that the ready output holds it off rather than losing a word.
    assign fill_if.valid = result_valid;
    assign fill_if.data = result_data;
    assign drain_if.ready = load_now;

    result_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_result_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .fill(fill_if.consumer),
        .drain(drain_if.producer)
    );

endmodule : sar_adc_serial_readout

`default_nettype wire

// >>> verif/sar_readout_chk.sv
// Concurrent checks on the serial readout pins, strobes and status.
// Assumes it is bound to the readout top and sees its ports only.
`timescale 1ns/10ps
`default_nettype none

module sar_readout_chk (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // Serial pins.
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    // Converter control and status.
    input wire logic track_hold_hold,
    input wire logic conv_start,
    input wire logic conv_step,
    input wire logic conv_abort,
    input wire logic power_down,
    input wire logic fully_powered
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    chk_start_drive: assert property ($fell(cs_n) |-> ##[2:6] serial_result_oe && track_hold_hold)
        else $error("output not driven after select fall");
    chk_start_pulse: assert property ($fell(cs_n) |-> ##[2:6] conv_start ##1 !conv_start)
        else $error("no single start pulse");
    chk_first_zero: assert property ($rose(serial_result_oe) |-> !serial_result_out)
        else $error("first bit not zero");
    chk_idle_quiet: assert property (cs_n [*6] |-> !serial_result_oe && !conv_step)
        else $error("activity while deselected");
    chk_step_low: assert property (conv_step |-> !sclk)
        else $error("step without serial clock fall");
    chk_abort_pulse: assert property (conv_abort |-> cs_n ##1 !conv_abort)
        else $error("abort without select rise");
    chk_abort_release: assert property (conv_abort |-> ##[0:2] !serial_result_oe)
        else $error("output still driven after abort");
    chk_pd_lag: assert property ($rose(power_down) |=> !fully_powered)
        else $error("still fully powered in power-down");
    chk_pd_cause: assert property ($rose(power_down) |-> cs_n)
        else $error("power-down without select rise");
    chk_wake_low: assert property ($fell(power_down) |-> !cs_n)
        else $error("wake outside a frame");

    cov_abort: cover property (conv_abort);
    cov_sleep: cover property ($rose(power_down));
    cov_wake: cover property ($fell(power_down));
endmodule : sar_readout_chk

bind sar_adc_serial_readout sar_readout_chk i_sar_readout_chk (
    .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .track_hold_hold(track_hold_hold), .conv_start(conv_start), .conv_step(conv_step),
    .conv_abort(conv_abort), .power_down(power_down), .fully_powered(fully_powered)
);

`default_nettype wire

// >>> verif/host_model.sv
// Host serial port model: drives select and serial clock, captures data.
// Assumes core_clk as time base; each serial phase lasts 8 core clocks.
`timescale 1ns/10ps
`default_nettype none

module host_model (
    // Clock.
    input wire logic core_clk,
    // Serial pins.
    output logic cs_n,
    output logic sclk,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    input wire logic track_hold_hold
);
    import sar_readout_pkg::*;
    logic last = 1'b0;
    // A released line shows the inverse of its last bit, so stale data cannot match.
    wire logic seen = serial_result_oe ? serial_result_out : ~last;

    always @(posedge core_clk) if (serial_result_oe) last <= serial_result_out;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
    end

    task automatic frame(input int n, output logic [15:0] d, output logic [15:0] h);
        d = 16'h0000;
        h = 16'h0000;
        @(posedge core_clk) #1 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat (8) @(posedge core_clk);
            #1 sclk = 1'b1;
            repeat (8) @(posedge core_clk);
            // bit stands over the whole high phase.
            #1 d[15-i] = seen;
            h[15-i] = track_hold_hold;
            sclk = 1'b0;
        end
        repeat (8) @(posedge core_clk);
    endtask : frame

    task automatic close();
        #1 cs_n = 1'b1;
        repeat (ACQ_CYCLES) @(posedge core_clk);
    endtask : close
endmodule : host_model

`default_nettype wire

// >>> verif/test_sar_adc_serial_readout.sv
// Self-checking bench of the serial readout: frames, aborts, power, FIFO.
// Assumes the host model paces serial pins; bench feeds results and straps.
`timescale 1ns/10ps
`default_nettype none

module test_sar_adc_serial_readout;
    import sar_readout_pkg::*;
    logic core_clk, rstn, cs_n, sclk, serial_result_out, serial_result_oe;
    logic track_hold_hold, conv_start, conv_step, conv_abort;
    logic power_down, fully_powered, frame_active, result_valid, result_ready;
    logic [1:0] variant_sel;
    logic [RESULT_W-1:0] result_data;
    logic [15:0] d, h;
    int err_count = 0;
    int total_checks = 0;
    int aborts = 0;
    int steps = 0;

    sar_adc_serial_readout i_sar_adc_serial_readout (
        .core_clk(core_clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
        .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
        .variant_sel(variant_sel), .track_hold_hold(track_hold_hold),
        .conv_start(conv_start), .conv_step(conv_step), .conv_abort(conv_abort),
        .result_data(result_data), .result_valid(result_valid), .result_ready(result_ready),
        .power_down(power_down), .fully_powered(fully_powered), .frame_active(frame_active)
    );
    host_model i_host_model (
        .core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe), .track_hold_hold(track_hold_hold)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (conv_abort === 1'b1) aborts++;
    always @(posedge core_clk) if (conv_step === 1'b1) steps++;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic push(input logic [11:0] w);
        int n;
        n = 0;
        @(posedge core_clk) #1 result_valid = 1'b1;
        result_data = w;
        while (result_ready !== 1'b1 && n < 100) begin
            @(posedge core_clk) #1 n++;
        end
        @(posedge core_clk) #1 result_valid = 1'b0;
    endtask : push

    function automatic logic [15:0] expect_word(input logic [1:0] sel, input logic [11:0] w);
        if (sel == SEL_10) return {4'h0, w[9:0], 2'h0};
        if (sel == SEL_8) return {4'h0, w[7:0], 4'h0};
        return {4'h0, w};
    endfunction : expect_word

    task automatic t_variants();
        for (int s = 0; s < 5; s++) begin
            logic [11:0] w;
            int a;
            int st;
            w = 12'ha53 + 12'(s * 291);
            a = aborts;
            #1 variant_sel = (s == 4) ? SEL_8 : 2'(s);
            push(w);
            st = steps;
            i_host_model.frame((s == 4) ? 12 : 16, d, h);
            check(d, expect_word(variant_sel, w));
            check(h, (variant_sel == SEL_8) ? 16'hffe0 : 16'hfff8);
            check(16'(steps - st), (s == 4) ? 16'h000c : 16'h0010);
            check({14'h0, serial_result_oe, frame_active},
                  (s == 4) ? 16'h0003 : 16'h0001);
            i_host_model.close();
            check(16'(aborts - a), 16'h0000);
        end
    endtask : t_variants

    task automatic t_early();
        for (int s = 0; s < 3; s++) begin
            int a;
            a = aborts;
            #1 variant_sel = 2'(s);
            push(12'h5a5);
            i_host_model.frame(15 - 2 * s, d, h);
            i_host_model.close();
            check({14'h0, serial_result_oe, power_down}, 16'h0000);
            check(16'(aborts - a), 16'h0001);
        end
    endtask : t_early

    task automatic t_power();
        #1 variant_sel = SEL_12;
        i_host_model.frame(1, d, h);
        i_host_model.close();
        check({15'h0, power_down}, 16'h0000);
        i_host_model.frame(8, d, h);
        i_host_model.close();
        check({15'h0, power_down}, 16'h0001);
        i_host_model.frame(9, d, h);
        i_host_model.close();
        check({15'h0, power_down}, 16'h0001);
        i_host_model.frame(16, d, h);
        i_host_model.close();
        check({14'h0, power_down, fully_powered}, 16'h0001);
    endtask : t_power

    task automatic t_fifo();
        #1 variant_sel = SEL_12;
        for (int i = 0; i < FIFO_DEPTH; i++) push(12'h100 + 12'(i));
        check({15'h0, result_ready}, 16'h0000);
        push(12'hfff);
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            i_host_model.frame(16, d, h);
            check(d, (i < FIFO_DEPTH) ? 16'h0100 + 16'(i) : 16'h0000);
            i_host_model.close();
        end
    endtask : t_fifo

    task automatic summarize();
        if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize

    initial begin
        rstn = 1'b0;
        variant_sel = SEL_12;
        result_valid = 1'b0;
        result_data = 12'h000;
        repeat (8) @(posedge core_clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge core_clk);
        t_variants();
        t_early();
        t_power();
        t_fifo();
        summarize();
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        err_count++;
        summarize();
    end
endmodule : test_sar_adc_serial_readout

`default_nettype wire
